/* File: rtl/cple_map.svh */
// Purpose: offsets, field positions, reset values and counts for the channel pair block
// Assumes: 8-bit registers on a plain strobe port
// Notes: definitions only
`ifndef CPLE_MAP_SVH
`define CPLE_MAP_SVH
`define CPLE_ADDR_W          10
`define CPLE_OFF_PAIR_EN     10'h209
`define CPLE_OFF_HDR_MODE    10'h20f
`define CPLE_OFF_LINK_CTRL   10'h20a
`define CPLE_OFF_LINK_STAT   10'h20b
`define CPLE_PAIR_EN_RST     8'h03
`define CPLE_HDR_MODE_RST    8'h00
`define CPLE_CTRL_RST        8'h00
`define CPLE_PAIR_EN_MASK    8'h07
`define CPLE_HDR_MODE_MASK   8'h03
`define CPLE_CTRL_MASK       8'h07
`define CPLE_BIT_AB          0
`define CPLE_BIT_CD          1
`define CPLE_BIT_SINGLE      2
`define CPLE_BIT_TX_EN       0
`define CPLE_BIT_CAL_EN      1
`define CPLE_BIT_MODE64      2
`define CPLE_SAMP_W          9
`define CPLE_FIFO_DEPTH      8
`define CPLE_BASE_LANES      3'h5
`define CPLE_BASE_CONV       3'h4
`define CPLE_SH_CRC          2'h0
`define CPLE_SH_FEC          2'h2
`endif

/* File: rtl/cple_pkg.sv */
// Purpose: shared types for the channel pair block
// Assumes: constants live in cple_map.svh
// Notes: none
package cple_pkg;
    typedef enum logic [1:0] {
        CPLE_SH_CRC12 = 2'b00,
        CPLE_SH_RSV1  = 2'b01,
        CPLE_SH_FEC   = 2'b10,
        CPLE_SH_RSV3  = 2'b11
    } cple_sh_t;
    typedef enum logic [0:0] {
        CPLE_IDLE = 1'b0,
        CPLE_RUN  = 1'b1
    } cple_state_t;
endpackage : cple_pkg

/* File: rtl/cple_fifo_if.sv */
// Purpose: valid/ready carrier between the framer and its sample fifo
// Assumes: one clock
// Notes: width fixed by the user
`timescale 1ns/1ps
interface cple_fifo_if #(parameter int W = 36);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : cple_fifo_if

/* File: rtl/cple_fifo.sv */
// Purpose: sample fifo with valid/ready on both sides
// Assumes: synchronous active-low reset
// Notes: full and empty are exact
`timescale 1ns/1ps
module cple_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 8
) (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    cple_fifo_if.snk    in_if,
    cple_fifo_if.src    out_if
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire           full  = (cnt_reg == (AW+1)'(DEPTH));
    wire           empty = (cnt_reg == '0);
    wire           push  = in_if.valid && !full;
    wire           pop   = out_if.ready && !empty;
    assign in_if.ready  = !full;
    assign out_if.valid = !empty;
    assign out_if.data  = mem_reg[rd_reg];
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_reg[wr_reg] <= in_if.data;
    end
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    a_fifo_no_overflow : assert property (@(posedge clk_i) disable iff (!rstn_i)
        full |-> ##1 (cnt_reg <= (AW+1)'(DEPTH)))
        else $error("fifo count passed depth");
endmodule : cple_fifo

/* File: rtl/cple_core.sv */
// Function
// - reset enables both pairs, single channel off, value three
// - single channel select runs only channel A; B goes off, A follows the lower pair enable
// - upper pair enable powers channels C and D
// - lower pair enable powers channels A and B
// - one pair off: half converters, lanes halved rounded up
// - odd base lanes with pair off: tail bits on top lane
// - lower pair off: C and D samples take A and B slots
// - two-bit sync header mode field, reset zero, upper bits zero
// - 64b/66b: mode zero sends crc-12, two sends fec
// - no command features; command fields zero, idle headers
//
// Purpose: channel pair enable, link scaling and sync header selection
// Assumes: samples arrive as four 9-bit channels A..D per word
// Notes: registers on an 8-bit strobe port, read data one cycle later
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "cple_map.svh"
module cple_core (
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    input  wire logic [`CPLE_ADDR_W-1:0]   addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    input  wire logic                      samp_valid_i,
    output logic                           samp_ready_o,
    input  wire logic [4*`CPLE_SAMP_W-1:0] samp_i,
    output logic                           frame_valid_o,
    input  wire logic                      frame_ready_i,
    output logic      [4*`CPLE_SAMP_W-1:0] frame_o,
    output logic      [3:0]                slot_used_o,
    output logic      [3:0]                chan_pwr_o,
    output logic      [2:0]                lane_count_o,
    output logic      [2:0]                conv_count_o,
    output logic                           tail_bits_o,
    output logic      [1:0]                sync_hdr_o,
    output logic      [2:0]                sync_cmd_o,
    output logic                           link_tx_en_o,
    output logic                           cal_en_o
);
    localparam int SW = `CPLE_SAMP_W;
    localparam logic [2:0] BASE_LANES = `CPLE_BASE_LANES;
    logic [7:0]  channel_pair_enable_reg;
    logic [7:0]  sync_header_mode_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  rdata_reg;
    logic [2:0]  act_ch_reg;
    logic [1:0]  act_sh_reg;
    logic [2:0]  lanes_reg;
    logic [2:0]  conv_reg;
    logic        tail_reg;
    cple_pkg::cple_state_t state_reg;
    cple_pkg::cple_state_t state_next;

    // address decode
    wire hit_ch   = (addr_i == `CPLE_OFF_PAIR_EN);
    wire hit_sh   = (addr_i == `CPLE_OFF_HDR_MODE);
    wire hit_ctrl = (addr_i == `CPLE_OFF_LINK_CTRL);
    wire hit_stat = (addr_i == `CPLE_OFF_LINK_STAT);
    wire tx_en    = ctrl_reg[`CPLE_BIT_TX_EN];
    wire tx_rise  = tx_en && (state_reg == cple_pkg::CPLE_IDLE);

    // upper bits zero
    // reserved bits are not stored, so a stray write cannot disturb them
    wire [7:0] ch_wr_val = wdata_i & `CPLE_PAIR_EN_MASK;
    wire [7:0] sh_wr_val = wdata_i & `CPLE_HDR_MODE_MASK;

    // register writes
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            channel_pair_enable_reg <= `CPLE_PAIR_EN_RST;
            sync_header_mode_reg    <= `CPLE_HDR_MODE_RST;
            ctrl_reg   <= `CPLE_CTRL_RST;
        end
        else if (wr_i)
        begin
            if (hit_ch)
                channel_pair_enable_reg <= ch_wr_val;
            if (hit_sh)
                sync_header_mode_reg <= sh_wr_val;
            if (hit_ctrl)
                ctrl_reg <= wdata_i & `CPLE_CTRL_MASK;
        end
    end

    // read mux, unmapped reads zero
    wire [7:0] stat_val = {1'b0, tail_reg, act_sh_reg, act_ch_reg, state_reg == cple_pkg::CPLE_RUN};
    wire [7:0] rd_mux = hit_ch   ? channel_pair_enable_reg :
                        hit_sh   ? sync_header_mode_reg    :
                        hit_ctrl ? ctrl_reg   :
                        hit_stat ? stat_val   : 8'h00;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            rdata_reg <= 8'h00;
        else if (rd_i)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 8'h00;
    end
    assign rdata_o = rdata_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            cple_pkg::CPLE_IDLE: if (tx_en) state_next = cple_pkg::CPLE_RUN;
            cple_pkg::CPLE_RUN:  if (!tx_en) state_next = cple_pkg::CPLE_IDLE;
            default:             state_next = cple_pkg::CPLE_IDLE;
        endcase
    end

    wire       pend_single = channel_pair_enable_reg[`CPLE_BIT_SINGLE];
    wire       pend_half   = pend_single || !channel_pair_enable_reg[`CPLE_BIT_AB]
                             || !channel_pair_enable_reg[`CPLE_BIT_CD];
    wire [2:0] lanes_half  = 3'((BASE_LANES + 3'h1) >> 1);
    wire [2:0] conv_half   = `CPLE_BASE_CONV >> 1;
    wire       pend_tail   = pend_half && BASE_LANES[0];

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_reg  <= cple_pkg::CPLE_IDLE;
            act_ch_reg <= 3'(`CPLE_PAIR_EN_RST);
            act_sh_reg <= 2'(`CPLE_HDR_MODE_RST);
            lanes_reg  <= `CPLE_BASE_LANES;
            conv_reg   <= `CPLE_BASE_CONV;
            tail_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (tx_rise)
            begin
                act_ch_reg <= channel_pair_enable_reg[2:0];
                act_sh_reg <= sync_header_mode_reg[1:0];
                lanes_reg  <= pend_half ? lanes_half : `CPLE_BASE_LANES;
                conv_reg   <= pend_half ? conv_half : `CPLE_BASE_CONV;
                tail_reg   <= pend_tail;
            end
        end
    end

    wire act_single = act_ch_reg[`CPLE_BIT_SINGLE];
    wire act_ab     = act_ch_reg[`CPLE_BIT_AB];
    wire act_cd     = act_ch_reg[`CPLE_BIT_CD];

    wire pwr_a = act_ab;
    wire pwr_b = act_ab && !act_single;
    wire pwr_c = act_cd && !act_single;
    wire pwr_d = act_cd && !act_single;
    assign chan_pwr_o   = {pwr_d, pwr_c, pwr_b, pwr_a};
    assign lane_count_o = lanes_reg;
    assign conv_count_o = conv_reg;
    assign tail_bits_o  = tail_reg;
    assign link_tx_en_o = (state_reg == cple_pkg::CPLE_RUN);
    assign cal_en_o     = ctrl_reg[`CPLE_BIT_CAL_EN];

    // header selection in 64b/66b only
    // reserved codes fall back to crc so the receiver still checks data
    wire mode64 = ctrl_reg[`CPLE_BIT_MODE64];
    assign sync_hdr_o = !mode64 ? 2'h0 :
                        (act_sh_reg == `CPLE_SH_FEC) ? `CPLE_SH_FEC : `CPLE_SH_CRC;
    assign sync_cmd_o = 3'h0;

    // sample path through fifo
    cple_fifo_if #(.W(4*SW)) fin_if ();
    cple_fifo_if #(.W(4*SW)) fout_if ();
    assign fin_if.valid  = samp_valid_i && link_tx_en_o;
    assign fin_if.data   = samp_i;
    assign samp_ready_o  = fin_if.ready && link_tx_en_o;
    cple_fifo #(.W(4*SW), .DEPTH(`CPLE_FIFO_DEPTH)) u_fifo (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .in_if  (fin_if),
        .out_if (fout_if)
    );

    wire [SW-1:0] s_a = fout_if.data[0*SW +: SW];
    wire [SW-1:0] s_b = fout_if.data[1*SW +: SW];
    wire [SW-1:0] s_c = fout_if.data[2*SW +: SW];
    wire [SW-1:0] s_d = fout_if.data[3*SW +: SW];
    wire [4*SW-1:0] packed_w =
        act_single ? {{(3*SW){1'b0}}, s_a} :
        !act_ab    ? {{(2*SW){1'b0}}, s_d, s_c} :
        !act_cd    ? {{(2*SW){1'b0}}, s_b, s_a} : fout_if.data;
    wire [3:0] used_w = act_single ? 4'h1 : (!act_ab || !act_cd) ? 4'h3 : 4'hf;

    // output stage, one frame held until taken
    wire out_free = !frame_valid_o || frame_ready_i;
    assign fout_if.ready = out_free;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            frame_valid_o <= 1'b0;
            frame_o       <= '0;
            slot_used_o   <= 4'h0;
        end
        else if (out_free)
        begin
            frame_valid_o <= fout_if.valid;
            if (fout_if.valid)
            begin
                frame_o     <= packed_w;
                slot_used_o <= used_w;
            end
        end
    end

    a_reset_value : assert property (@(posedge clk_i)
        !rstn_i |=> (channel_pair_enable_reg == 8'h03 && sync_header_mode_reg == 8'h00))
        else $error("reset values wrong");
    a_single_only_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
        act_single |-> (chan_pwr_o[3:1] == 3'b000))
        else $error("single mode left b c d on");
    a_upper_pwr : assert property (@(posedge clk_i) disable iff (!rstn_i)
        !act_single |-> (chan_pwr_o[3:2] == {2{act_cd}}))
        else $error("c d power mismatch");
    a_lower_pwr : assert property (@(posedge clk_i) disable iff (!rstn_i)
        chan_pwr_o[0] == act_ab)
        else $error("a power mismatch");
    a_lane_scale : assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tx_rise && pend_half) |=> (lane_count_o == 3'h3 && conv_count_o == 3'h2))
        else $error("lane or converter scaling wrong");
    a_tail_pad : assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_rise |=> (tail_bits_o == $past(pend_half)))
        else $error("tail bits wrong");
    sequence s_pop_ab_off;
        fout_if.valid && out_free && !act_ab && !act_single;
    endsequence
    a_slot_move : assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pop_ab_off |=> (frame_o[2*SW-1:0] == $past(fout_if.data[4*SW-1:2*SW])))
        else $error("c d samples not moved");
    a_hdr_select : assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode64 && act_sh_reg == 2'h2) |-> sync_hdr_o == 2'h2)
        else $error("fec not selected");
    a_cmd_idle : assert property (@(posedge clk_i) disable iff (!rstn_i)
        sync_cmd_o == 3'h0)
        else $error("command field not idle");
    sequence s_running;
        link_tx_en_o && tx_en;
    endsequence
    a_geom_hold : assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_running |=> $stable(act_ch_reg) && $stable(act_sh_reg))
        else $error("geometry changed while running");
    a_ready_stopped : assert property (@(posedge clk_i) disable iff (!rstn_i)
        !link_tx_en_o |-> !samp_ready_o)
        else $error("samples taken while stopped");
    a_hdr_plain : assert property (@(posedge clk_i) disable iff (!rstn_i)
        !mode64 |-> (sync_hdr_o == 2'h0))
        else $error("header mode outside 64b66b");
    a_hdr_reserved : assert property (@(posedge clk_i) disable iff (!rstn_i)
        (mode64 && act_sh_reg != 2'h2) |-> (sync_hdr_o == 2'h0))
        else $error("crc not selected");
    a_full_geom : assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tx_rise && !pend_half) |=>
        (lane_count_o == BASE_LANES && conv_count_o == `CPLE_BASE_CONV && !tail_bits_o))
        else $error("full geometry wrong");
    // slot mask with lower pair off
    a_slots_ab_off : assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pop_ab_off |=> (slot_used_o == 4'h3))
        else $error("slot mask wrong");
    sequence s_pop_single;
        fout_if.valid && out_free && act_single;
    endsequence
    a_single_slot : assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_pop_single |=> (frame_o[4*SW-1:SW] == '0 && slot_used_o == 4'h1))
        else $error("single channel frame not packed");
    // a stalled consumer must see the same frame again
    sequence s_frame_stall;
        frame_valid_o && !frame_ready_i;
    endsequence
    a_frame_hold : assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_frame_stall |=> (frame_valid_o && $stable(frame_o) && $stable(slot_used_o)))
        else $error("frame changed before taken");
    // read data only after a read
    a_rdata_idle : assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rd_i |=> (rdata_o == 8'h00))
        else $error("read data outside its cycle");
    a_hdr_bits : assert property (@(posedge clk_i) disable iff (!rstn_i)
        sync_header_mode_reg[7:2] == 6'h00)
        else $error("reserved header bits stored");
endmodule : cple_core

/* File: verification/cple_rx_model.sv */
// Purpose: frame consumer in place of the link receiver
// Assumes: one clock, a frame is taken on valid and ready
// Notes: stall_i makes it slow, frames kept in order
`timescale 1ns/1ps
module cple_rx_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        stall_i,
    input  wire logic        frame_valid_i,
    input  wire logic [35:0] frame_i,
    output logic             frame_ready_o
);
    logic [35:0] got_q[$];
    // never ready in reset, so nothing leaks in early
    assign frame_ready_o = rstn_i && !stall_i;
    always @(posedge clk_i)
    begin
        if (frame_valid_i === 1'b1 && frame_ready_o)
            got_q.push_back(frame_i);
    end
endmodule : cple_rx_model

/* File: verification/channel_pair_enable_link_scaling_test.sv */
// Purpose: self-checking bench for the channel pair block
// Assumes: core with its fifo, consumer model on the frame side
// Notes: settings change only with transmit stopped, except one case
`timescale 1ns/1ps
`include "cple_map.svh"
module channel_pair_enable_link_scaling_test;
    localparam logic [9:0] a_ch = `CPLE_OFF_PAIR_EN;
    localparam logic [9:0] a_sh = `CPLE_OFF_HDR_MODE;
    localparam logic [9:0] a_ct = `CPLE_OFF_LINK_CTRL;
    localparam logic [9:0] a_st = `CPLE_OFF_LINK_STAT;
    localparam logic [35:0] s0  = 36'h876543210;
    logic        clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic        samp_valid_i = 1'b0, stall = 1'b0, frame_ready, samp_ready_o, frame_valid_o;
    logic        tail_bits_o, link_tx_en_o, cal_en_o;
    logic [9:0]  addr_i = '0;
    logic [7:0]  wdata_i = '0, rdata_o, rd_v;
    logic [35:0] samp_i = '0, frame_o;
    logic [3:0]  slot_used_o, chan_pwr_o;
    logic [2:0]  lane_count_o, conv_count_o, sync_cmd_o;
    logic [1:0]  sync_hdr_o;
    int          fails = 0, tests_run = 0, cyc = 0;

    cple_core dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o),
        .samp_i(samp_i), .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready), .frame_o(frame_o),
        .slot_used_o(slot_used_o), .chan_pwr_o(chan_pwr_o), .lane_count_o(lane_count_o),
        .conv_count_o(conv_count_o), .tail_bits_o(tail_bits_o), .sync_hdr_o(sync_hdr_o),
        .sync_cmd_o(sync_cmd_o), .link_tx_en_o(link_tx_en_o), .cal_en_o(cal_en_o));
    cple_rx_model rx (.clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall), .frame_valid_i(frame_valid_o),
        .frame_i(frame_o), .frame_ready_o(frame_ready));

    always #2.5 clk_i = ~clk_i;
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            end_sim();
        end
    end

    task end_sim;
        $display("counts: %0d compared, %0d wrong", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task chk(input logic [35:0] seen, input logic [35:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // strobe one cycle, read data caught mid-cycle after the taking edge
    task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge clk_i);
        rd_v = rdata_o;
        @(posedge clk_i);
    endtask : bus

    task start(input logic [7:0] c);
        bus(1'b1, a_ct, 8'h00);
        bus(1'b1, a_ct, c);
        repeat (2) @(posedge clk_i);
        chk(link_tx_en_o, 1, "running");
    endtask : start

    task push(input logic [35:0] d);
        int k;
        samp_i       <= d;
        samp_valid_i <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(negedge clk_i);
            if (samp_ready_o === 1'b1)
                break;
            @(posedge clk_i);
        end
        @(posedge clk_i);
        samp_valid_i <= 1'b0;
    endtask : push

    task wait_rx(input int n);
        int k;
        for (k = 0; k < 100 && rx.got_q.size() < n; k++)
            @(negedge clk_i);
        chk(rx.got_q.size(), n, "frames received");
        @(posedge clk_i);
    endtask : wait_rx

    task reset_and_regs;
        bus(1'b0, a_ch, 8'h00);
        chk(rd_v, 8'h03, "pair enable reset");
        bus(1'b0, a_sh, 8'h00);
        chk(rd_v, 8'h00, "header mode reset");
        chk({chan_pwr_o, lane_count_o, conv_count_o}, {4'hf, 3'h5, 3'h4}, "reset geometry");
        chk(samp_ready_o, 0, "ready while stopped");
        bus(1'b1, a_ch, 8'hff);
        bus(1'b0, a_ch, 8'h00);
        chk(rd_v, 8'h07, "reserved pair bits");
        bus(1'b1, a_sh, 8'hff);
        bus(1'b0, a_sh, 8'h00);
        chk(rd_v, 8'h03, "reserved header bits");
        bus(1'b0, 10'h300, 8'h00);
        chk(rd_v, 8'h00, "unmapped read");
        bus(1'b1, a_ct, 8'h02);
        chk(cal_en_o, 1, "calibration on");
        bus(1'b1, a_sh, 8'h00);
        $display("test reset_and_regs done");
    endtask : reset_and_regs

    task pair_case(input logic [7:0] ch, input logic [3:0] pwr, input logic [6:0] geo,
                   input logic [3:0] slots, input logic [35:0] exp);
        logic [35:0] m;
        int          k;
        // calibration and transmit off before touching the pairs
        bus(1'b1, a_ct, 8'h00);
        bus(1'b1, a_ch, ch);
        start(8'h01);
        chk(chan_pwr_o, pwr, "channel power");
        // single channel geometry is left open, so only pair cases are judged
        if (ch != 8'h05)
            chk({lane_count_o, conv_count_o, tail_bits_o}, geo, "link geometry");
        push(s0);
        wait_rx(1);
        chk(slot_used_o, slots, "slot mask");
        for (k = 0; k < 4; k++)
            m[k*9 +: 9] = {9{slots[k]}};
        chk(rx.got_q.pop_front() & m, exp, "frame slots");
        $display("test pair_case %h done", ch);
    endtask : pair_case

    task sync_modes;
        int k;
        for (k = 3; k >= 0; k--)
        begin
            bus(1'b1, a_ct, 8'h00);
            bus(1'b1, a_sh, 8'(k));
            start(8'h05);
            chk(sync_hdr_o, (k == 2) ? 2'h2 : 2'h0, "header kind");
            chk(sync_cmd_o, 3'h0, "command field");
        end
        bus(1'b1, a_sh, 8'h02);
        chk(sync_hdr_o, 2'h0, "header held while running");
        start(8'h05);
        chk(sync_hdr_o, 2'h2, "header after restart");
        start(8'h01);
        chk(sync_hdr_o, 2'h0, "header outside 64b66b");
        $display("test sync_modes done");
    endtask : sync_modes

    task fill_drain;
        int n;
        int k;
        bus(1'b1, a_ct, 8'h00);
        bus(1'b1, a_ch, 8'h03);
        start(8'h01);
        stall        <= 1'b1;
        samp_valid_i <= 1'b1;
        samp_i       <= '0;
        n = 0;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk_i);
            if (samp_ready_o !== 1'b1)
                break;
            @(posedge clk_i);
            n++;
            samp_i <= 36'(n);
        end
        @(posedge clk_i);
        samp_valid_i <= 1'b0;
        // eight in the fifo plus the one frame the output stage holds
        chk(n, `CPLE_FIFO_DEPTH + 1, "words before refusal");
        stall <= 1'b0;
        wait_rx(n);
        for (k = 0; k < n; k++)
            chk(rx.got_q.pop_front(), 36'(k), "drain order");
        $display("test fill_drain done");
    endtask : fill_drain

    // mid-run reset with settings away from their reset values
    task reset_again;
        bus(1'b1, a_ct, 8'h00);
        bus(1'b1, a_ch, 8'h01);
        bus(1'b1, a_sh, 8'h02);
        start(8'h05);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk({link_tx_en_o, cal_en_o, frame_valid_o, chan_pwr_o}, {3'b000, 4'hf}, "after reset");
        bus(1'b0, a_ch, 8'h00);
        chk(rd_v, 8'h03, "pair enable after reset");
        bus(1'b0, a_sh, 8'h00);
        chk(rd_v, 8'h00, "header mode after reset");
        bus(1'b0, a_st, 8'h00);
        chk(rd_v, 8'h06, "status after reset");
        $display("test reset_again done");
    endtask : reset_again

    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        reset_and_regs();
        pair_case(8'h03, 4'hf, {3'h5, 3'h4, 1'b0}, 4'hf, s0);
        pair_case(8'h01, 4'h3, {3'h3, 3'h2, 1'b1}, 4'h3, {18'h0, s0[17:0]});
        pair_case(8'h02, 4'hc, {3'h3, 3'h2, 1'b1}, 4'h3, {18'h0, s0[35:18]});
        pair_case(8'h05, 4'h1, 7'h0, 4'h1, {27'h0, s0[8:0]});
        sync_modes();
        fill_drain();
        reset_again();
        end_sim();
    end
endmodule : channel_pair_enable_link_scaling_test
